// ===== csd_pkg.sv
// Package for the compare, skip, decimal adjust and decrement executor
package csd_pkg;
	localparam logic [7:0] OP_CMP_LESS    = 8'h30;
	localparam logic [7:0] OP_CMP_EQUAL   = 8'h31;
	localparam logic [7:0] OP_CMP_GREATER = 8'h32;
	localparam logic [6:0] OP_DEC_ADJ     = 7'h17;
	localparam logic [6:0] OP_DEC_BYTE    = 7'h03;
	localparam logic [6:0] OP_DEC_SKIPZ   = 7'h0B;
	localparam logic [3:0] NIBBLE_LIMIT   = 4'h9;
	localparam logic [3:0] NIBBLE_FIX     = 4'h6;
	localparam logic [7:0] WORKING_REGISTER_RESET     = 8'h00;
	localparam int         DEST_BIT       = 8;

	typedef struct packed {
		logic overflow_flag;
		logic zero;
		logic digit_carry_flag;
		logic carry;
	} csd_flags_t;

	localparam csd_flags_t FLAGS_RESET = '0;

	typedef struct packed {
		logic       we;
		logic [7:0] addr;
		logic [7:0] data;
	} csd_mem_wr_t;
endpackage : csd_pkg

// ===== csd_exec.sv
// Executor for compare-skip, decimal adjust and decrement instructions
`timescale 1ns/1ns
module csd_exec (
	input  wire logic                 SYS_CLK,
	input  wire logic                 RST_N,
	input  wire logic                 INSTR_VALID,
	input  wire logic [15:0]          INSTR,
	input  wire logic [7:0]           MEM_RDATA,
	output logic [7:0]                MEM_RADDR,
	output csd_pkg::csd_mem_wr_t      MEM_WR,
	output logic [7:0]                WORKING_REGISTER,
	output csd_pkg::csd_flags_t       FLAGS,
	output logic                      SKIP_NEXT,
	output logic                      IDLE_CYCLE,
	output logic                      DONE
);
	import csd_pkg::*;

	// Operand arrives combinationally from data memory during the same cycle
	logic [7:0] op_hi;
	logic       is_lt;
	logic       is_eq;
	logic       is_gt;
	logic       is_daw;
	logic       is_dec;
	logic       is_dsz;
	logic       dest_sel;
	logic [3:0] lo_nib;
	logic [4:0] hi_sum;
	logic       lo_fix;
	logic       hi_fix;
	logic [7:0] daw_res;
	logic [8:0] dec_wide;
	logic [7:0] dec_res;
	logic       dec_ov;
	logic       dec_dc;
	logic       cmp_skip;
	logic       run;
	logic       idle;
	logic       dest_sel_q;

	assign op_hi    = INSTR[15:8];
	assign run      = INSTR_VALID && !idle;
	assign is_lt    = run && (op_hi == OP_CMP_LESS);
	assign is_eq    = run && (op_hi == OP_CMP_EQUAL);
	assign is_gt    = run && (op_hi == OP_CMP_GREATER);
	assign is_daw   = run && (INSTR[15:9] == OP_DEC_ADJ);
	assign is_dec   = run && (INSTR[15:9] == OP_DEC_BYTE);
	assign is_dsz   = run && (INSTR[15:9] == OP_DEC_SKIPZ);
	assign dest_sel = INSTR[DEST_BIT];

	// Unsigned comparisons on the addressed byte against the working register
	assign cmp_skip = (is_eq && (MEM_RDATA == WORKING_REGISTER))
		|| (is_gt && (MEM_RDATA > WORKING_REGISTER))
		|| (is_lt && (MEM_RDATA < WORKING_REGISTER));

	// Decimal adjust works on the working register, not the addressed byte
	assign lo_fix  = (WORKING_REGISTER[3:0] > NIBBLE_LIMIT) || FLAGS.digit_carry_flag;
	assign lo_nib  = lo_fix ? WORKING_REGISTER[3:0] + NIBBLE_FIX : WORKING_REGISTER[3:0];
	assign hi_fix  = (WORKING_REGISTER[7:4] > NIBBLE_LIMIT) || FLAGS.carry;
	assign hi_sum  = hi_fix ? {1'b0, WORKING_REGISTER[7:4]} + {1'b0, NIBBLE_FIX}
		: {1'b0, WORKING_REGISTER[7:4]};
	// Low-nibble carry is dropped, matching the nibble-wise formula
	assign daw_res = {hi_sum[3:0], lo_nib};

	assign dec_wide = {1'b0, MEM_RDATA} - 9'h001;
	assign dec_res  = dec_wide[7:0];
	assign dec_ov   = (MEM_RDATA == 8'h80);
	assign dec_dc   = (MEM_RDATA[3:0] != 4'h0);

	always_comb begin
		MEM_RADDR = INSTR[7:0];
	end

	// Idle cycle replaces the prefetched instruction after a taken skip
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			idle <= 1'b0;
		end else begin
			idle <= cmp_skip || (is_dsz && (dec_res == 8'h00));
		end
	end

	// Destination choice kept one cycle for the checks below
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			dest_sel_q <= 1'b0;
		end else begin
			dest_sel_q <= dest_sel;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			SKIP_NEXT  <= 1'b0;
			IDLE_CYCLE <= 1'b0;
			DONE       <= 1'b0;
		end else begin
			SKIP_NEXT  <= cmp_skip || (is_dsz && (dec_res == 8'h00));
			IDLE_CYCLE <= INSTR_VALID && idle;
			DONE       <= run && (is_lt || is_eq || is_gt || is_daw || is_dec || is_dsz);
		end
	end

	// Memory write port; compares never write
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			MEM_WR <= '0;
		end else begin
			MEM_WR.we   <= 1'b0;
			MEM_WR.addr <= INSTR[7:0];
			MEM_WR.data <= 8'h00;
			if (is_daw) begin
				MEM_WR.we   <= 1'b1;
				MEM_WR.data <= daw_res;
			end else if ((is_dec || is_dsz) && dest_sel) begin
				MEM_WR.we   <= 1'b1;
				MEM_WR.data <= dec_res;
			end
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			WORKING_REGISTER <= WORKING_REGISTER_RESET;
		end else if (is_daw && !dest_sel) begin
			WORKING_REGISTER <= daw_res;
		end else if ((is_dec || is_dsz) && !dest_sel) begin
			WORKING_REGISTER <= dec_res;
		end
	end

	// Compares and the skip-decrement leave flags alone
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			FLAGS <= FLAGS_RESET;
		end else if (is_daw) begin
			FLAGS.carry <= hi_sum[4];
		end else if (is_dec) begin
			FLAGS.overflow_flag    <= dec_ov;
			FLAGS.carry            <= (MEM_RDATA != 8'h00);
			FLAGS.digit_carry_flag <= dec_dc;
			FLAGS.zero             <= (dec_res == 8'h00);
		end
	end

	AST_EQ_SKIP: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		is_eq && (MEM_RDATA == WORKING_REGISTER) |=> SKIP_NEXT)
		else $error("equal compare did not skip");
	AST_GT_SKIP: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		is_gt |=> SKIP_NEXT == $past(MEM_RDATA > WORKING_REGISTER))
		else $error("greater compare skip wrong");
	AST_LT_SKIP: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		is_lt |=> SKIP_NEXT == $past(MEM_RDATA < WORKING_REGISTER))
		else $error("less compare skip wrong");
	AST_IDLE_FOLLOWS: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		SKIP_NEXT && INSTR_VALID |=> IDLE_CYCLE && !DONE && !MEM_WR.we)
		else $error("skip not followed by idle cycle");
	AST_CMP_NO_SIDE: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(is_lt || is_eq || is_gt) |=> $stable(FLAGS) && $stable(WORKING_REGISTER) && !MEM_WR.we)
		else $error("compare changed state");
	AST_DAW_DEST: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		is_daw |=> MEM_WR.we && (dest_sel_q ? $stable(WORKING_REGISTER)
			: WORKING_REGISTER == MEM_WR.data))
		else $error("decimal adjust destination wrong");
	AST_DAW_FLAGS: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		is_daw |=> FLAGS.zero == $past(FLAGS.zero)
			&& FLAGS.digit_carry_flag == $past(FLAGS.digit_carry_flag) && !SKIP_NEXT)
		else $error("decimal adjust touched other flags");
	AST_DAW_LOW: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		is_daw && !FLAGS.digit_carry_flag && WORKING_REGISTER[3:0] <= 4'h9
		|=> MEM_WR.data[3:0] == $past(WORKING_REGISTER[3:0]))
		else $error("low nibble altered");
	AST_DSZ_SKIP: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		is_dsz |=> $stable(FLAGS) && SKIP_NEXT == ($past(MEM_RDATA) == 8'h01))
		else $error("decrement skip wrong");

	// Decode seen from the raw word, not from the decoder's own terms
	AST_LT_DECODE: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		INSTR_VALID && !idle && INSTR[15:8] == OP_CMP_LESS |=> DONE && !MEM_WR.we)
		else $error("less compare not decoded");

	AST_EQ_DECODE: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		INSTR_VALID && !idle && INSTR[15:8] == OP_CMP_EQUAL |=> DONE && !MEM_WR.we)
		else $error("equal compare not decoded");

	AST_GT_DECODE: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		INSTR_VALID && !idle && INSTR[15:8] == OP_CMP_GREATER |=> DONE && !MEM_WR.we)
		else $error("greater compare not decoded");

	AST_DAW_DECODE: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		INSTR_VALID && !idle && INSTR[15:9] == OP_DEC_ADJ
		|=> DONE && MEM_WR.we && MEM_WR.addr == $past(INSTR[7:0]))
		else $error("decimal adjust not decoded");

	AST_UNDECODED: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		INSTR_VALID && !idle && !(is_lt || is_eq || is_gt || is_daw || is_dec || is_dsz)
		|=> !DONE && !MEM_WR.we)
		else $error("undecoded word had an effect");

	AST_EQ_NOSKIP: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		is_eq && MEM_RDATA != WORKING_REGISTER |=> !SKIP_NEXT)
		else $error("equal compare skipped on mismatch");

	AST_GT_NOSKIP_EQ: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		is_gt && MEM_RDATA == WORKING_REGISTER |=> !SKIP_NEXT)
		else $error("greater compare skipped on equal");

	AST_GT_NOSKIP_LESS: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		is_gt && MEM_RDATA < WORKING_REGISTER |=> !SKIP_NEXT)
		else $error("greater compare skipped on less");

	AST_LT_NOSKIP_EQ: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		is_lt && MEM_RDATA == WORKING_REGISTER |=> !SKIP_NEXT)
		else $error("less compare skipped on equal");

	AST_LT_NOSKIP_MORE: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		is_lt && MEM_RDATA > WORKING_REGISTER |=> !SKIP_NEXT)
		else $error("less compare skipped on greater");

	// The discarded word must leave no trace at all
	AST_SKIP_KILLS: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		idle && INSTR_VALID
		|=> !DONE && !MEM_WR.we && $stable(WORKING_REGISTER) && $stable(FLAGS))
		else $error("discarded instruction had an effect");

	AST_IDLE_ONCE: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		IDLE_CYCLE |=> !IDLE_CYCLE)
		else $error("idle cycle lasted too long");

	AST_IDLE_CAUSE: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		IDLE_CYCLE |-> $past(SKIP_NEXT))
		else $error("idle cycle without a skip");

	AST_NO_SKIP_OTHER: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		is_daw || is_dec |=> !SKIP_NEXT)
		else $error("non-skip instruction skipped");

	AST_CMP_FLAGS_KEEP: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		is_lt || is_eq || is_gt |=> FLAGS == $past(FLAGS))
		else $error("compare changed flags");

	AST_DAW_LOW_FIX: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		is_daw && (WORKING_REGISTER[3:0] > 4'h9 || FLAGS.digit_carry_flag)
		|=> MEM_WR.data[3:0] == $past(WORKING_REGISTER[3:0] + 4'h6))
		else $error("low nibble not corrected");

	AST_DAW_HIGH: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		is_daw && !FLAGS.carry && WORKING_REGISTER[7:4] <= 4'h9
		|=> MEM_WR.data[7:4] == $past(WORKING_REGISTER[7:4]) && !FLAGS.carry)
		else $error("high nibble altered");

	AST_DAW_HIGH_FIX: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		is_daw && (WORKING_REGISTER[7:4] > 4'h9 || FLAGS.carry)
		|=> MEM_WR.data[7:4] == $past(WORKING_REGISTER[7:4] + 4'h6))
		else $error("high nibble not corrected");

	AST_DAW_WORKING_REGISTER_KEEP: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		is_daw && dest_sel |=> $stable(WORKING_REGISTER))
		else $error("decimal adjust wrote register on select one");

	AST_DAW_WORKING_REGISTER_SET: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		is_daw && !dest_sel |=> WORKING_REGISTER == MEM_WR.data)
		else $error("decimal adjust missed register on select zero");

	AST_DAW_ONE_CYCLE: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		is_daw |=> DONE)
		else $error("decimal adjust not single cycle");

	// Decrement results and flags, either destination
	AST_DEC_VALUE: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		is_dec |=> (MEM_WR.we ? MEM_WR.data : WORKING_REGISTER) == $past(MEM_RDATA - 8'h01))
		else $error("decrement value wrong");

	AST_DSZ_VALUE: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		is_dsz |=> (MEM_WR.we ? MEM_WR.data : WORKING_REGISTER) == $past(MEM_RDATA - 8'h01))
		else $error("skip decrement value wrong");

	AST_DEC_ZERO: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		is_dec |=> FLAGS.zero == ($past(MEM_RDATA) == 8'h01))
		else $error("decrement zero flag wrong");

	AST_DEC_CARRY: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		is_dec |=> FLAGS.carry == ($past(MEM_RDATA) != 8'h00))
		else $error("decrement carry flag wrong");

	AST_DEC_OVER: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		is_dec |=> FLAGS.overflow_flag == ($past(MEM_RDATA) == 8'h80))
		else $error("decrement overflow flag wrong");

	AST_DEC_DC: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		is_dec |=> FLAGS.digit_carry_flag == ($past(MEM_RDATA[3:0]) != 4'h0))
		else $error("decrement digit carry wrong");

	AST_DEC_ADDR: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(is_dec || is_dsz) && dest_sel |=> MEM_WR.we && MEM_WR.addr == $past(INSTR[7:0]))
		else $error("decrement location write wrong");

	AST_DEC_WORKING_REGISTER_KEEP: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(is_dec || is_dsz) && dest_sel |=> $stable(WORKING_REGISTER))
		else $error("decrement wrote register on location select");

	AST_DEC_NO_WRITE: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(is_dec || is_dsz) && !dest_sel |=> !MEM_WR.we)
		else $error("decrement wrote location on register select");

	AST_DSZ_DONE: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		is_dsz |=> DONE)
		else $error("skip decrement not completed");
endmodule : csd_exec

// ===== csd_exec_bench.sv
// Self-checking bench for the compare, skip, adjust and decrement executor
`timescale 1ns/1ns
module csd_exec_bench;
	import csd_pkg::*;
	logic        SYS_CLK     = 1'b0;
	logic        RST_N       = 1'b0;
	logic        INSTR_VALID = 1'b0;
	logic [15:0] INSTR       = 16'h0000;
	logic [7:0]  MEM_RDATA   = 8'h00;
	logic [7:0]  MEM_RADDR;
	csd_mem_wr_t MEM_WR;
	logic [7:0]  WORKING_REGISTER;
	csd_flags_t  FLAGS;
	logic        SKIP_NEXT;
	logic        IDLE_CYCLE;
	logic        DONE;
	logic [31:0] exp_q[$];
	logic [31:0] seed      = 32'h36C1;
	logic [31:0] act;
	logic [31:0] v;
	logic [7:0]  working_register      = WORKING_REGISTER_RESET;
	csd_flags_t  flg       = FLAGS_RESET;
	logic        skip_pend = 1'b0;
	int          bad_count = 0;
	int          n_checks  = 0;
	// Last entry is undecoded on purpose
	logic [7:0]  ops [10]  = '{8'h30, 8'h31, 8'h32, 8'h2E, 8'h2F, 8'h06, 8'h07, 8'h16, 8'h17, 8'h55};

	csd_exec dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .INSTR_VALID(INSTR_VALID), .INSTR(INSTR),
		.MEM_RDATA(MEM_RDATA), .MEM_RADDR(MEM_RADDR), .MEM_WR(MEM_WR),
		.WORKING_REGISTER(WORKING_REGISTER), .FLAGS(FLAGS), .SKIP_NEXT(SKIP_NEXT),
		.IDLE_CYCLE(IDLE_CYCLE), .DONE(DONE));

	initial forever #5 SYS_CLK = ~SYS_CLK;

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	task automatic cmp_res(input logic [31:0] e, input logic [31:0] a);
		n_checks++;
		if (a !== e) begin
			bad_count++;
			$display("unexpected at %0t: expected %h got %h", $time, e, a);
		end
	endtask : cmp_res

	// Model first, then drive, so the note is queued before the answer
	task automatic issue(input logic [15:0] ins, input logic [7:0] rd);
		logic [4:0] hi;
		logic [3:0] lo;
		logic [7:0] r;
		logic       sk;
		logic       we;
		logic       hit;
		sk = 1'b0;
		we = 1'b0;
		hit = 1'b1;
		r = rd - 8'h01;
		if (skip_pend) begin
			exp_q.push_back({4'b0100, 16'h0000, working_register, flg});
			hit = 1'b0;
		end else if (ins[15:8] == OP_CMP_LESS) sk = rd < working_register;
		else if (ins[15:8] == OP_CMP_EQUAL) sk = rd == working_register;
		else if (ins[15:8] == OP_CMP_GREATER) sk = rd > working_register;
		else if (ins[15:9] == OP_DEC_ADJ) begin
			lo = (working_register[3:0] > NIBBLE_LIMIT || flg.digit_carry_flag) ? working_register[3:0] + NIBBLE_FIX : working_register[3:0];
			hi = {1'b0, working_register[7:4]} + ((working_register[7:4] > NIBBLE_LIMIT || flg.carry) ? 5'h06 : 5'h00);
			r = {hi[3:0], lo};
			flg.carry = hi[4];
			we = 1'b1;
			if (!ins[DEST_BIT]) working_register = r;
		end else if (ins[15:9] == OP_DEC_BYTE || ins[15:9] == OP_DEC_SKIPZ) begin
			if (ins[12]) sk = r == 8'h00;
			else flg = '{rd == 8'h80, r == 8'h00, rd[3:0] != 4'h0, rd != 8'h00};
			we = ins[DEST_BIT];
			if (!we) working_register = r;
		end else hit = 1'b0;
		if (hit) exp_q.push_back({2'b10, sk, we, we ? r : 8'h00, we ? ins[7:0] : 8'h00, working_register, flg});
		skip_pend = sk;
		@(posedge SYS_CLK);
		#1;
		INSTR_VALID = 1'b1;
		INSTR = ins;
		MEM_RDATA = rd;
	endtask : issue

	task automatic print_verdict();
		$display("checks %0d errors %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : print_verdict

	always @(posedge SYS_CLK) begin
		#2;
		if (DONE === 1'b1 || IDLE_CYCLE === 1'b1) begin
			act = {DONE, IDLE_CYCLE, SKIP_NEXT, MEM_WR.we, MEM_WR.we ? MEM_WR.data : 8'h00,
				MEM_WR.we ? MEM_WR.addr : 8'h00, WORKING_REGISTER, FLAGS};
			cmp_res(exp_q.size() > 0 ? exp_q.pop_front() : 32'hFFFFFFFF, act);
		end
	end

	initial begin
		repeat (16) @(posedge SYS_CLK);
		#1;
		RST_N = 1'b1;
		for (int i = 0; i < 400; i++) begin
			v = rnd();
			// Bias operands toward equality, zero result and overflow corners
			issue({ops[v[3:0] % 10], v[15:8]}, v[16] ? working_register : (v[17] ? {v[25], 6'h00, ~v[25]} : v[31:24]));
			if (v[20:18] == 3'h0 && !skip_pend) begin
				@(posedge SYS_CLK);
				#1;
				INSTR_VALID = 1'b0;
			end
		end
		@(posedge SYS_CLK);
		#1;
		INSTR_VALID = 1'b0;
		repeat (4) @(posedge SYS_CLK);
		#3;
		cmp_res(32'(exp_q.size()), 32'h00000000);
		print_verdict();
	end

	initial begin
		#20000;
		bad_count++;
		print_verdict();
	end
endmodule : csd_exec_bench
